// [bench/far_bus_agent.sv]
`timescale 1ns/1ns
`default_nettype none
module far_bus_agent (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic slow,
   input wire logic sc_addr_valid,
   input wire logic sc_msg_valid,
   output logic sc_addr_ready,
   output logic sc_msg_ready
);
   // Requester as target; slow mode inserts three wait states per phase
   logic [1:0] wait_q;
   always_ff @(posedge core_clk) begin
      if (reset || !(sc_addr_valid || sc_msg_valid) || sc_addr_ready || sc_msg_ready) begin
         wait_q <= 2'h0;
      end else if (wait_q != 2'h3) begin
         wait_q <= wait_q + 2'h1;
      end
   end
   // Top address bits never looked at here
   assign sc_addr_ready = sc_addr_valid && (!slow || wait_q == 2'h3);
   assign sc_msg_ready = sc_msg_valid && (!slow || wait_q == 2'h3);
endmodule
`default_nettype wire

// [bench/split_completion_address_builder_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module split_completion_address_builder_bench;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic cfg_wr = 1'b0, cfg_rd = 1'b0, req_valid = 1'b0, imm_done = 1'b0, imm_on_secondary = 1'b0;
   logic master_abort = 1'b0, sc_data_done = 1'b0, sc_disconnect = 1'b0, fwd_from_primary = 1'b0, slow = 1'b0;
   logic [7:0] cfg_addr = 8'h00, sub_bus_number = 8'h00;
   logic [3:0] cfg_be = 4'h0, req_cmd = 4'h0, req_attr_cbe = 4'h0, sc_cmd, sc_attr_cbe;
   logic [31:0] cfg_wdata = 32'h0000_0000, req_addr = 32'h0000_0000, req_attr_ad = 32'h0000_0000;
   logic [31:0] fwd_addr = 32'h0000_0000, cfg_rdata, sc_addr, sc_attr_ad, sc_msg_data;
   logic [12:0] sc_bytes_moved = 13'h0000, fwd_bytes_to_adb;
   logic cfg_rdata_valid, req_ready, sc_addr_valid, sc_addr_ready, sc_msg_valid, sc_msg_ready, busy, fwd_take;
   int fails = 0;
   int cmp_count = 0;
   always #10 core_clk = ~core_clk;
   split_completion_builder dut (.core_clk, .reset, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
      .cfg_rdata_valid, .req_valid, .req_ready, .req_addr, .req_cmd, .req_attr_ad, .req_attr_cbe, .imm_done,
      .imm_on_secondary, .master_abort, .sc_addr_valid, .sc_addr_ready, .sc_addr, .sc_cmd, .sc_attr_ad,
      .sc_attr_cbe, .sc_msg_valid, .sc_msg_ready, .sc_msg_data, .sc_data_done, .sc_disconnect, .sc_bytes_moved,
      .busy, .fwd_addr, .fwd_from_primary, .sub_bus_number, .fwd_take, .fwd_bytes_to_adb);
   far_bus_agent agent (.core_clk, .reset, .slow, .sc_addr_valid, .sc_msg_valid, .sc_addr_ready, .sc_msg_ready);
   // ==========================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
      cfg_wr = wr;
      cfg_rd = !wr;
      cfg_addr = a;
      cfg_be = (a == 8'h18) ? 4'h2 : 4'hf;
      cfg_wdata = d;
      tick();
      if (!wr) begin
         chk("cfg_rdata_valid", cfg_rdata_valid, 1);
      end
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      // Let an edge pass so the next access raises its strobe from low
      tick();
      chk("cfg_rdata_valid idle", cfg_rdata_valid, 0);
   endtask
   task automatic request(input logic [3:0] c, input logic [31:0] a, input logic [31:0] t, input logic sec);
      chk("req_ready", req_ready, 1);
      req_valid = 1'b1;
      req_cmd = c;
      req_addr = a;
      req_attr_ad = t;
      tick();
      req_valid = 1'b0;
      imm_on_secondary = sec;
      imm_done = 1'b1;
      tick();
      imm_done = 1'b0;
   endtask
   task automatic phase(input logic [31:0] ea, input logic [31:0] et, input logic [3:0] ec);
      int n;
      n = 0;
      while (sc_addr_valid !== 1'b1 && n < 4) begin
         tick();
         n++;
      end
      chk("sc_addr_valid", sc_addr_valid, 1);
      chk("busy", busy, 1);
      chk("sc_cmd", sc_cmd, split_completion_pkg::CMD_SPLIT_COMPLETION);
      chk("sc_addr", sc_addr, ea);
      chk("sc_attr_ad", sc_attr_ad, et);
      chk("sc_attr_cbe", sc_attr_cbe, ec);
      while (sc_addr_valid === 1'b1 && n < 12) begin
         tick();
         n++;
      end
      chk("sc_addr_valid done", sc_addr_valid, 0);
   endtask
   task automatic end_data(input logic disc, input logic [12:0] moved);
      sc_disconnect = disc;
      sc_data_done = !disc;
      sc_bytes_moved = moved;
      tick();
      sc_disconnect = 1'b0;
      sc_data_done = 1'b0;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_config();
      cfg(1'b1, 8'h18, 32'hffff_5aff);
      cfg(1'b1, 8'hf4, 32'hffff_1234);
      cfg(1'b1, 8'h40, 32'hffff_ffff);
      cfg(1'b0, 8'h18, 32'h0000_0000);
      chk("secondary_bus_number", cfg_rdata[15:8], 32'h0000_005a);
      cfg(1'b0, 8'hf4, 32'h0000_0000);
      chk("bridge_bus_device_status", cfg_rdata, 32'h0000_1234);
      cfg(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped", cfg_rdata, 32'h0000_0000);
   endtask
   task automatic t_writes();
      logic [3:0] cmds [2];
      int n;
      cmds = '{split_completion_pkg::CMD_IO_WRITE, split_completion_pkg::CMD_CFG_WRITE};
      slow = 1'b1;
      foreach (cmds[i]) begin
         request(cmds[i], 32'h0000_0047, 32'hea34_5610, 1'b0);
         phase(32'h2a34_5600, 32'h2012_3404, 4'h0);
         n = 0;
         while (sc_msg_valid !== 1'b1 && n < 4) begin
            tick();
            n++;
         end
         chk("sc_msg_valid", sc_msg_valid, 1);
         chk("sc_msg_data", sc_msg_data, 32'h0000_0000);
         repeat (5) tick();
         chk("idle", req_ready, 1);
      end
      slow = 1'b0;
   endtask
   task automatic t_bursts();
      logic [3:0] cmds [2];
      cmds = '{split_completion_pkg::CMD_MEM_READ_BLOCK, split_completion_pkg::CMD_ALIAS_READ_BLOCK};
      foreach (cmds[i]) begin
         request(cmds[i], 32'h0000_1035, 32'h0111_2200, 1'b1);
         phase(32'h0111_2235, 32'h005a_0000, 4'h0);
         end_data(1'b1, 13'h004b);
         phase(32'h0111_2200, 32'h005a_00b5, 4'hf);
         end_data(1'b0, 13'h0000);
         chk("idle", req_ready, 1);
      end
   endtask
   task automatic t_dwords();
      logic [3:0] cmds [3];
      cmds = '{split_completion_pkg::CMD_MEM_READ_DWORD, split_completion_pkg::CMD_IO_READ,
         split_completion_pkg::CMD_CFG_READ};
      foreach (cmds[i]) begin
         request(cmds[i], 32'h0000_007c, 32'h0300_0100, 1'b0);
         phase(32'h0300_0100, 32'h0012_3404, 4'h0);
         end_data(1'b0, 13'h0000);
         chk("idle", req_ready, 1);
      end
   endtask
   task automatic t_abort();
      imm_done = 1'b1;
      tick();
      imm_done = 1'b0;
      tick();
      chk("stray finish", sc_addr_valid, 0);
      req_valid = 1'b1;
      req_cmd = split_completion_pkg::CMD_IO_WRITE;
      tick();
      req_valid = 1'b0;
      master_abort = 1'b1;
      imm_done = 1'b1;
      tick();
      master_abort = 1'b0;
      imm_done = 1'b0;
      chk("abort valid", sc_addr_valid, 0);
      chk("abort idle", req_ready, 1);
      chk("abort busy", busy, 0);
   endtask
   task automatic t_forward();
      sub_bus_number = 8'h60;
      fwd_addr = 32'h005c_0010;
      fwd_from_primary = 1'b1;
      tick();
      chk("fwd_take", fwd_take, 1);
      chk("fwd_bytes_to_adb", fwd_bytes_to_adb, 32'h0000_0070);
      fwd_from_primary = 1'b0;
      tick();
      chk("fwd_take", fwd_take, 0);
      fwd_addr = 32'h0070_007f;
      tick();
      chk("fwd_take", fwd_take, 1);
      chk("fwd_bytes_to_adb", fwd_bytes_to_adb, 32'h0000_0001);
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      #1;
      reset = 1'b0;
      t_config();
      t_writes();
      t_bursts();
      t_dwords();
      t_abort();
      t_forward();
      complete_run();
   end
   // Whole run is under a hundred cycles; this leaves a wide margin
   initial begin
      #100000;
      fails++;
      complete_run();
   end
endmodule
`default_nettype wire

// [bench/split_completion_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module split_completion_checker (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic [31:0] req_attr_ad,
   input wire logic imm_done,
   input wire logic master_abort,
   input wire logic sc_addr_valid,
   input wire logic sc_addr_ready,
   input wire logic [31:0] sc_addr,
   input wire logic [3:0] sc_cmd,
   input wire logic [31:0] sc_attr_ad,
   input wire logic [3:0] sc_attr_cbe,
   input wire logic [31:0] fwd_addr,
   input wire logic [12:0] fwd_bytes_to_adb
);
   // ==========================================
   // Request tracking
   logic wait_q;
   logic wait_d;
   logic [31:0] attr_q;
   logic [31:0] attr_d;
   always_comb begin
      wait_d = wait_q;
      attr_d = attr_q;
      if (req_valid && req_ready) begin
         wait_d = 1'b1;
         attr_d = req_attr_ad;
      end else if (imm_done || master_abort) begin
         wait_d = 1'b0;
      end
   end
   always_ff @(posedge core_clk) begin
      wait_q <= reset ? 1'b0 : wait_d;
      attr_q <= attr_d;
   end
   // ==========================================
   // Properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   a_done_gives_addr: assert property (wait_q && imm_done && !master_abort |=> sc_addr_valid)
      else $error("No completion after immediate finish");
   a_abort_no_compl: assert property (wait_q && master_abort |=> req_ready && !sc_addr_valid)
      else $error("Completion after master abort");
   a_addr_held: assert property (sc_addr_valid && !sc_addr_ready |=> sc_addr_valid && $stable(sc_addr))
      else $error("Address phase dropped or changed");
   a_requester_id_copy: assert property (sc_addr_valid |-> sc_addr[29:8] == attr_q[29:8])
      else $error("Requester fields not copied");
   a_bit_seven_zero: assert property (sc_addr_valid |-> !sc_addr[7])
      else $error("Address bit 7 set");
   a_top_bits_zero: assert property (sc_addr_valid |-> sc_addr[31:30] == 2'h0)
      else $error("Top address bits set");
   a_split_cmd_code: assert property (sc_addr_valid |-> sc_cmd == split_completion_pkg::CMD_SPLIT_COMPLETION)
      else $error("Wrong completion command");
   a_msg_attr_fields: assert property (sc_addr_valid && sc_attr_ad[29]
      |-> {sc_attr_cbe, sc_attr_ad[7:0]} == 12'h004 && !sc_attr_ad[31] && sc_addr[6:0] == 7'h00)
      else $error("Message attributes wrong");
   a_adb_distance: assert property (fwd_bytes_to_adb == 13'h0080 - {6'h00, fwd_addr[6:0]})
      else $error("Distance to boundary wrong");
endmodule
bind split_completion_builder split_completion_checker chk (.core_clk, .reset, .req_valid, .req_ready,
   .req_attr_ad, .imm_done, .master_abort, .sc_addr_valid, .sc_addr_ready, .sc_addr, .sc_cmd, .sc_attr_ad,
   .sc_attr_cbe, .fwd_addr, .fwd_bytes_to_adb);
`default_nettype wire

// [design/split_completion_builder.sv]
`timescale 1ns/1ns
`default_nettype none
module split_completion_builder (
   input wire logic core_clk,
   input wire logic reset,
   // Configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_rdata_valid,
   // Forwarded split request capture
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [31:0] req_addr,
   input wire logic [3:0] req_cmd,
   input wire logic [31:0] req_attr_ad,
   input wire logic [3:0] req_attr_cbe,
   // Far bus outcome
   input wire logic imm_done,
   input wire logic imm_on_secondary,
   input wire logic master_abort,
   // Split completion address and attribute phase
   output logic sc_addr_valid,
   input wire logic sc_addr_ready,
   output logic [31:0] sc_addr,
   output logic [3:0] sc_cmd,
   output logic [31:0] sc_attr_ad,
   output logic [3:0] sc_attr_cbe,
   // Split completion message data phase
   output logic sc_msg_valid,
   input wire logic sc_msg_ready,
   output logic [31:0] sc_msg_data,
   // Read data phase outcome
   input wire logic sc_data_done,
   input wire logic sc_disconnect,
   input wire logic [12:0] sc_bytes_moved,
   output logic busy,
   // Forwarding check of incoming completions
   input wire logic [31:0] fwd_addr,
   input wire logic fwd_from_primary,
   input wire logic [7:0] sub_bus_number,
   output logic fwd_take,
   output logic [12:0] fwd_bytes_to_adb
);

   // ==========================================================
   // Configuration registers
   localparam logic [5:0] SEC_DWORD = split_completion_pkg::SEC_BUS_OFFSET[7:2];
   localparam logic [1:0] SEC_LANE = split_completion_pkg::SEC_BUS_OFFSET[1:0];
   localparam logic [5:0] BSR_DWORD = split_completion_pkg::BRIDGE_STATUS_OFFSET[7:2];

   logic [7:0] secondary_bus_number_q, secondary_bus_number_d;
   logic [15:0] bridge_bus_device_status_q, bridge_bus_device_status_d;
   logic [31:0] cfg_rdata_q, cfg_rdata_d;
   logic cfg_rdata_valid_q, cfg_rdata_valid_d;

   always_comb begin
      secondary_bus_number_d = secondary_bus_number_q;
      bridge_bus_device_status_d = bridge_bus_device_status_q;
      cfg_rdata_d = cfg_rdata_q;
      cfg_rdata_valid_d = cfg_rd;
      if (cfg_wr && cfg_addr[7:2] == SEC_DWORD && cfg_be[SEC_LANE]) begin
         secondary_bus_number_d = cfg_wdata[8*SEC_LANE +: 8];
      end
      if (cfg_wr && cfg_addr[7:2] == BSR_DWORD) begin
         if (cfg_be[0]) begin
            bridge_bus_device_status_d[7:0] = cfg_wdata[7:0];
         end
         if (cfg_be[1]) begin
            bridge_bus_device_status_d[15:8] = cfg_wdata[15:8];
         end
      end
      if (cfg_rd) begin
         // Only this block's bytes are returned; other space reads zero here
         cfg_rdata_d = 32'h0000_0000;
         if (cfg_addr[7:2] == SEC_DWORD) begin
            cfg_rdata_d[8*SEC_LANE +: 8] = secondary_bus_number_q;
         end else if (cfg_addr[7:2] == BSR_DWORD) begin
            cfg_rdata_d[15:0] = bridge_bus_device_status_q;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         secondary_bus_number_q <= split_completion_pkg::SEC_BUS_RESET;
         bridge_bus_device_status_q <= split_completion_pkg::BRIDGE_STATUS_RESET;
         cfg_rdata_q <= 32'h0000_0000;
         cfg_rdata_valid_q <= 1'b0;
      end else begin
         secondary_bus_number_q <= secondary_bus_number_d;
         bridge_bus_device_status_q <= bridge_bus_device_status_d;
         cfg_rdata_q <= cfg_rdata_d;
         cfg_rdata_valid_q <= cfg_rdata_valid_d;
      end
   end

   assign cfg_rdata = cfg_rdata_q;
   assign cfg_rdata_valid = cfg_rdata_valid_q;

   // ==========================================================
   // Request store and completion sequencing
   split_completion_pkg::sc_state_t state_q, state_d;
   logic [31:0] addr_q, addr_d;
   logic [3:0] cmd_q, cmd_d;
   logic [31:0] rattr_q, rattr_d;
   logic [12:0] remain_q, remain_d;
   logic first_q, first_d;
   logic [15:0] cid_q, cid_d;
   logic [31:0] sc_addr_q, sc_addr_d;
   logic [31:0] sc_attr_ad_q, sc_attr_ad_d;
   logic [3:0] sc_attr_cbe_q, sc_attr_cbe_d;
   logic [31:0] sc_msg_data_q, sc_msg_data_d;
   logic [12:0] req_count;
   logic is_msg;
   logic is_burst;
   logic [11:0] count_field;
   logic [6:0] lower;

   always_comb begin
      // Zero byte count in the request means the full 4096
      req_count = (req_attr_cbe == 4'h0 && req_attr_ad[7:0] == 8'h00) ? 13'h1000 :
                  {1'b0, req_attr_cbe, req_attr_ad[7:0]};
      is_msg = split_completion_pkg::is_write_req(cmd_q);
      is_burst = split_completion_pkg::is_burst_read(cmd_q);
      count_field = is_msg ? split_completion_pkg::MSG_BYTE_COUNT : remain_q[11:0];
      // Message, DWORD request or resumed sequence all start at offset zero
      lower = (is_burst && first_q && !is_msg) ? addr_q[6:0] : 7'h00;
   end

   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      cmd_d = cmd_q;
      rattr_d = rattr_q;
      remain_d = remain_q;
      first_d = first_q;
      cid_d = cid_q;
      sc_addr_d = sc_addr_q;
      sc_attr_ad_d = sc_attr_ad_q;
      sc_attr_cbe_d = sc_attr_cbe_q;
      sc_msg_data_d = sc_msg_data_q;
      case (state_q)
         split_completion_pkg::ST_IDLE: begin
            if (req_valid) begin
               addr_d = req_addr;
               cmd_d = req_cmd;
               rattr_d = req_attr_ad;
               first_d = 1'b1;
               // Non-burst requests complete a single DWORD
               remain_d = split_completion_pkg::is_burst_read(req_cmd) ? req_count : 13'h0004;
               state_d = split_completion_pkg::ST_WAIT_DONE;
            end
         end
         split_completion_pkg::ST_WAIT_DONE: begin
            // The far completer never splits again; abort just drops the entry
            if (master_abort) begin
               state_d = split_completion_pkg::ST_IDLE;
            end else if (imm_done) begin
               if (imm_on_secondary) begin
                  cid_d = {secondary_bus_number_q, 8'h00};
               end else begin
                  cid_d = bridge_bus_device_status_q;
               end
               state_d = split_completion_pkg::ST_SEND_ADDR;
            end
         end
         split_completion_pkg::ST_SEND_ADDR: begin
            if (sc_addr_ready) begin
               first_d = 1'b0;
               if (is_msg) begin
                  state_d = split_completion_pkg::ST_SEND_MSG;
               end else begin
                  state_d = split_completion_pkg::ST_DATA;
               end
            end
         end
         split_completion_pkg::ST_SEND_MSG: begin
            if (sc_msg_ready) begin
               state_d = split_completion_pkg::ST_IDLE;
            end
         end
         split_completion_pkg::ST_DATA: begin
            if (sc_disconnect && sc_bytes_moved < remain_q) begin
               // Resume with what is left of the sequence
               remain_d = remain_q - sc_bytes_moved;
               state_d = split_completion_pkg::ST_SEND_ADDR;
            end else if (sc_disconnect || sc_data_done) begin
               state_d = split_completion_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = split_completion_pkg::ST_IDLE;
         end
      endcase

      // Address phase image, rebuilt each time a phase is launched
      if (state_d == split_completion_pkg::ST_SEND_ADDR) begin
         sc_addr_d = 32'h0000_0000;
         sc_addr_d[6:0] = (state_q == split_completion_pkg::ST_DATA) ? 7'h00 : lower;
         sc_addr_d[23:8] = rattr_q[23:8];
         sc_addr_d[28:24] = rattr_q[28:24];
         sc_addr_d[split_completion_pkg::RO_BIT] = rattr_q[split_completion_pkg::RO_BIT];
         sc_attr_ad_d = 32'h0000_0000;
         sc_attr_ad_d[7:0] = count_field[7:0];
         sc_attr_ad_d[31:8] = {8'h00, cid_d};
         sc_attr_ad_d[split_completion_pkg::SCM_BIT] = is_msg;
         sc_attr_ad_d[split_completion_pkg::SCE_BIT] = 1'b0;
         // Full remaining count always sent, so never modified
         sc_attr_ad_d[split_completion_pkg::BCM_BIT] = 1'b0;
         sc_attr_cbe_d = count_field[11:8];
         if (state_q == split_completion_pkg::ST_DATA) begin
            sc_attr_ad_d[7:0] = remain_d[7:0];
            sc_attr_cbe_d = remain_d[11:8];
         end
         sc_msg_data_d = {split_completion_pkg::MSG_CLASS_NORMAL, split_completion_pkg::MSG_INDEX_NORMAL,
                          20'h0_0000};
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= split_completion_pkg::ST_IDLE;
         addr_q <= 32'h0000_0000;
         cmd_q <= 4'h0;
         rattr_q <= 32'h0000_0000;
         remain_q <= 13'h0000;
         first_q <= 1'b0;
         cid_q <= 16'h0000;
         sc_addr_q <= 32'h0000_0000;
         sc_attr_ad_q <= 32'h0000_0000;
         sc_attr_cbe_q <= 4'h0;
         sc_msg_data_q <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         addr_q <= addr_d;
         cmd_q <= cmd_d;
         rattr_q <= rattr_d;
         remain_q <= remain_d;
         first_q <= first_d;
         cid_q <= cid_d;
         sc_addr_q <= sc_addr_d;
         sc_attr_ad_q <= sc_attr_ad_d;
         sc_attr_cbe_q <= sc_attr_cbe_d;
         sc_msg_data_q <= sc_msg_data_d;
      end
   end

   // ==========================================================
   // Outputs
   assign req_ready = (state_q == split_completion_pkg::ST_IDLE);
   assign busy = (state_q != split_completion_pkg::ST_IDLE);
   assign sc_addr_valid = (state_q == split_completion_pkg::ST_SEND_ADDR);
   assign sc_msg_valid = (state_q == split_completion_pkg::ST_SEND_MSG);
   assign sc_addr = sc_addr_q;
   assign sc_cmd = split_completion_pkg::CMD_SPLIT_COMPLETION;
   assign sc_attr_ad = sc_attr_ad_q;
   assign sc_attr_cbe = sc_attr_cbe_q;
   assign sc_msg_data = sc_msg_data_q;

   // ==========================================================
   // Forwarding check
   split_completion_forward u_forward (
      .fwd_addr(fwd_addr),
      .fwd_from_primary(fwd_from_primary),
      .sec_bus(secondary_bus_number_q),
      .sub_bus(sub_bus_number),
      .fwd_take(fwd_take),
      .fwd_bytes_to_adb(fwd_bytes_to_adb)
   );

endmodule
`default_nettype wire

// [design/split_completion_forward.sv]
`timescale 1ns/1ns
`default_nettype none
module split_completion_forward (
   input wire logic [31:0] fwd_addr,
   input wire logic fwd_from_primary,
   input wire logic [7:0] sec_bus,
   input wire logic [7:0] sub_bus,
   output logic fwd_take,
   output logic [12:0] fwd_bytes_to_adb
);
   logic [7:0] req_bus;
   logic [6:0] lower;

   always_comb begin
      req_bus = fwd_addr[split_completion_pkg::BUS_LSB +: 8];
      lower = fwd_addr[split_completion_pkg::LOWER_ADDR_MSB:0];
      // Downstream if requester lies behind the bridge, upstream otherwise
      if (fwd_from_primary) begin
         fwd_take = (req_bus >= sec_bus) && (req_bus <= sub_bus);
      end else begin
         fwd_take = (req_bus < sec_bus) || (req_bus > sub_bus);
      end
      fwd_bytes_to_adb = split_completion_pkg::ADB_SIZE - {6'h00, lower};
   end
endmodule
`default_nettype wire

// [design/split_completion_pkg.sv]
// Operation
// - On immediate completion the bridge builds a Split Completion back to requester.
// - Completion address derives from the original request like any completer.
// - Completer ID names the bridge on the bus that completed immediately.
// - Primary completion takes bus, device, function from bridge status low sixteen bits.
// - Secondary completion uses secondary bus number, device and function zero.
// - Immediately completed writes also carry a Split Completion Message as data.
// - Address phase drives AD with content copied from request address and attributes.
// - Forwarding uses lower address to locate start against the disconnect boundary.
// - Lower address copies request bits 6:0 for first non-message burst-read completion.
// - Lower address is zero on resume at boundary, DWORD requests, and messages.
// - Address bit 7 is driven zero.
// - Requester function, device, bus fields copy from requester attributes.
// - Forwarding decision examines the requester bus number field.
// - Five-bit tag copies from requester attributes.
// - Relaxed-ordering bit optionally copies from requester attributes.
// - Top two address bits driven zero; requester ignores them.
// - Command lines carry the Split Completion command during the address phase.
// - Attributes hold twelve-bit byte count (zero means 4096) and completer ID.
// - For a message, message bit one, byte count four, byte-count-modified zero.
`default_nettype none
package split_completion_pkg;

   // ==========================================================
   // Configuration offsets and reset values
   localparam logic [7:0] SEC_BUS_OFFSET = 8'h19;
   localparam logic [7:0] BRIDGE_STATUS_OFFSET = 8'hf4;
   localparam logic [7:0] SEC_BUS_RESET = 8'h00;
   localparam logic [15:0] BRIDGE_STATUS_RESET = 16'h0000;

   // ==========================================================
   // Address and attribute field positions
   localparam int LOWER_ADDR_MSB = 6;
   localparam int FUNC_LSB = 8;
   localparam int DEV_LSB = 11;
   localparam int BUS_LSB = 16;
   localparam int TAG_LSB = 24;
   localparam int RO_BIT = 29;
   localparam int SCM_BIT = 29;
   localparam int SCE_BIT = 30;
   localparam int BCM_BIT = 31;

   // ==========================================================
   // Bus commands and message content
   localparam logic [3:0] CMD_IO_READ = 4'h2;
   localparam logic [3:0] CMD_IO_WRITE = 4'h3;
   localparam logic [3:0] CMD_MEM_READ_DWORD = 4'h6;
   localparam logic [3:0] CMD_ALIAS_READ_BLOCK = 4'h8;
   localparam logic [3:0] CMD_CFG_READ = 4'ha;
   localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
   localparam logic [3:0] CMD_SPLIT_COMPLETION = 4'hc;
   localparam logic [3:0] CMD_MEM_READ_BLOCK = 4'he;
   localparam logic [11:0] MSG_BYTE_COUNT = 12'h004;
   localparam logic [3:0] MSG_CLASS_NORMAL = 4'h0;
   localparam logic [7:0] MSG_INDEX_NORMAL = 8'h00;
   localparam logic [12:0] ADB_SIZE = 13'h0080;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_DONE,
      ST_SEND_ADDR,
      ST_SEND_MSG,
      ST_DATA
   } sc_state_t;

   function automatic logic is_burst_read(input logic [3:0] cmd);
      is_burst_read = (cmd == CMD_MEM_READ_BLOCK) || (cmd == CMD_ALIAS_READ_BLOCK);
   endfunction

   function automatic logic is_write_req(input logic [3:0] cmd);
      is_write_req = (cmd == CMD_IO_WRITE) || (cmd == CMD_CFG_WRITE);
   endfunction

endpackage
`default_nettype wire
